// file: rtl/sao_pkg.sv
package sao_pkg;
  localparam int ACC_W = 32;
  localparam int HALF_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int PC_W = 16;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_PRODUCT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_STACK_HEAD = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_MEM = 8'h18;
  // Status field positions
  localparam int BIT_CARRY = 0;
  localparam int BIT_FSYNC = 1;
  localparam int BIT_HOLD = 2;
  localparam int PM_LO = 3;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0006;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Byte lane of the control word that carries the op code
  localparam int OP_LANE = 0;
  // Product shift amounts for select codes 1, 2 and 3
  localparam int PSHIFT_SEL1_LEFT = 1;
  localparam int PSHIFT_SEL2_LEFT = 4;
  localparam int PSHIFT_SEL3_RIGHT = 6;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_LOAD_PRODUCT = 4'h1, OP_POP = 4'h2,
    OP_STACK_TO_MEM = 4'h3, OP_MEM_TO_STACK = 4'h4, OP_PUSH = 4'h5,
    OP_SUB_EXIT = 4'h6, OP_CLR_CARRY = 4'h7, OP_CLR_FSYNC = 4'h8,
    OP_CLR_HOLD = 4'h9, OP_ROT_LEFT = 4'hA, OP_ROT_RIGHT = 4'hB
  } sao_op_t;
  typedef struct packed {
    logic [1:0] product_shift_select;
    logic hold_behaviour_select;
    logic frame_sync_required;
    logic carry;
  } sao_status_t;
endpackage

// file: rtl/sao_core.sv
module sao_core
  import sao_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic frame_sync_required, // Serial port needs frame pulses
  output logic hold_behaviour_select // Hold mode select
);
  // The copy-up pop needs a head and at least one level beneath it
  if (DEPTH < 2) begin
    $error("DEPTH must be at least 2");
  end

  // Datapath state
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] product;
  logic [PC_W-1:0] pc;
  logic [HALF_W-1:0] mem_word;
  sao_status_t status;
  logic [HALF_W-1:0] stack [DEPTH];
  // Write side bookkeeping
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic op_go;
  sao_op_t op;
  logic aw_take;
  logic w_take;
  logic next_aw_have;
  logic next_w_have;
  logic next_bvalid;

  // Reset value of the status flops, cut from the bus-wide constant
  localparam sao_status_t STATUS_INIT =
    STATUS_RESET[$bits(sao_status_t)-1:0];

  // Merge strobed bytes over an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Product shift: 0 none, 1 left 1, 2 left 4, 3 right 6 signed
  function automatic logic [ACC_W-1:0] shift_product(
      input logic [ACC_W-1:0] p, input logic [1:0] sel);
    logic [ACC_W-1:0] r;
    r = p;
    case (sel)
      2'h1: r = p << PSHIFT_SEL1_LEFT;
      2'h2: r = p << PSHIFT_SEL2_LEFT;
      2'h3: r = ACC_W'($signed(p) >>> PSHIFT_SEL3_RIGHT);
      default: r = p;
    endcase
    return r;
  endfunction

  // Offsets that take a write; the stack head is read-only from the bus
  function automatic logic writable(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_ACC || a == ADDR_PRODUCT
           || a == ADDR_STATUS || a == ADDR_PC || a == ADDR_MEM;
  endfunction

  // Status as a bus word; bits above the fields read as zero
  function automatic logic [ACC_W-1:0] status_word(input sao_status_t s);
    return ACC_W'(s);
  endfunction

  // Status fields cut back out of a bus word
  function automatic sao_status_t status_of(input logic [ACC_W-1:0] w);
    return w[$bits(sao_status_t)-1:0];
  endfunction

  // Handshake terms of this cycle
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;
  assign op_go = wr_fire && aw_addr == ADDR_CTRL && w_strb[OP_LANE];
  assign op = sao_op_t'(w_data[$bits(sao_op_t)-1:0]);

  // Next holding state of the write side, worked out one cycle ahead
  // so that the ready outputs can be plain flops
  always_comb begin
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_bvalid = s_axi_bvalid;
    if (aw_take) begin
      next_aw_have = 1'b1;
    end else if (wr_fire) begin
      next_aw_have = 1'b0;
    end
    if (w_take) begin
      next_w_have = 1'b1;
    end else if (wr_fire) begin
      next_w_have = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
    end else if (s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write channel capture; address and data accepted in either order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Readies are flops fed from the next state, so each channel takes at
  // most one item per write and nothing while a response waits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !next_aw_have && !next_bvalid;
      s_axi_wready <= !next_w_have && !next_bvalid;
    end
  end

  // Write response; unmapped or read-only offsets answer with an error
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_bvalid <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= writable(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Accumulator, product, PC, memory word and status
  // Ops and plain register writes never meet in one cycle, since
  // op_go is only ever true together with wr_fire
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      product <= '0;
      pc <= '0;
      mem_word <= '0;
      status <= STATUS_INIT;
    end else if (op_go) begin
      case (op)
        OP_LOAD_PRODUCT:
          acc <= shift_product(product, status.product_shift_select);
        OP_POP: acc <= {{HALF_W{1'b0}}, stack[0]};
        OP_STACK_TO_MEM: mem_word <= stack[0];
        OP_SUB_EXIT: pc <= stack[0];
        OP_CLR_CARRY: status.carry <= 1'b0;
        OP_CLR_FSYNC: status.frame_sync_required <= 1'b0;
        OP_CLR_HOLD: status.hold_behaviour_select <= 1'b0;
        OP_ROT_LEFT: begin
          acc <= {acc[ACC_W-2:0], status.carry};
          status.carry <= acc[ACC_W-1];
        end
        OP_ROT_RIGHT: begin
          acc <= {status.carry, acc[ACC_W-1:1]};
          status.carry <= acc[0];
        end
        default: acc <= acc;
      endcase
    end else if (wr_fire) begin
      case (aw_addr)
        ADDR_ACC: acc <= merge(acc, w_data, w_strb);
        ADDR_PRODUCT: product <= merge(product, w_data, w_strb);
        ADDR_PC: pc <= PC_W'(merge(ACC_W'(pc), w_data, w_strb));
        ADDR_MEM:
          mem_word <= HALF_W'(merge(ACC_W'(mem_word), w_data, w_strb));
        ADDR_STATUS:
          status <= status_of(merge(status_word(status), w_data, w_strb));
        default: mem_word <= mem_word;
      endcase
    end
  end

  // Hardware stack; no reset, no underflow or overflow flags
  // Pops copy upward and keep the bottom, so it replicates on exhaustion
  // Contents are unknown after reset; nothing marks a level as empty, so
  // software fills every level before it trusts what a pop returns
  always_ff @(posedge mclk) begin
    if (op_go) begin
      case (op)
        OP_POP, OP_STACK_TO_MEM, OP_SUB_EXIT: begin
          for (int i = 0; i < DEPTH - 1; i++) begin
            stack[i] <= stack[i+1];
          end
        end
        OP_PUSH, OP_MEM_TO_STACK: begin
          for (int i = 1; i < DEPTH; i++) begin
            stack[i] <= stack[i-1];
          end
          stack[0] <= (op == OP_PUSH) ? acc[HALF_W-1:0] : mem_word;
        end
        default: stack[0] <= stack[0];
      endcase
    end
  end

  // Read channel; one read outstanding
  // arready pulses one cycle per request, so a held arvalid is taken
  // once; the address is decoded at the handshake edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL: s_axi_rdata <= 32'h0000_0000;
          ADDR_ACC: s_axi_rdata <= acc;
          ADDR_PRODUCT: s_axi_rdata <= product;
          ADDR_STATUS: s_axi_rdata <= status_word(status);
          ADDR_STACK_HEAD: s_axi_rdata <= ACC_W'(stack[0]);
          ADDR_PC: s_axi_rdata <= ACC_W'(pc);
          ADDR_MEM: s_axi_rdata <= ACC_W'(mem_word);
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Mode outputs registered from status
  // One flop behind status: the serial and hold logic see a new mode
  // one cycle after the write or clear op that made it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_required <= STATUS_RESET[BIT_FSYNC];
      hold_behaviour_select <= STATUS_RESET[BIT_HOLD];
    end else begin
      frame_sync_required <= status.frame_sync_required;
      hold_behaviour_select <= status.hold_behaviour_select;
    end
  end
endmodule

// file: tb/sao_props.sv
module sao_props (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic frame_sync_required, // Serial mode
  input wire logic hold_behaviour_select // Hold mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Mode bits move only with a completed register write
  a_fsync_on_write: assert property (
    $changed(frame_sync_required) |->
      $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("frame sync mode moved without a write");
  a_hold_on_write: assert property (
    $changed(hold_behaviour_select) |->
      $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("hold mode moved without a write");
  // Answers stand until taken, so a slow master loses nothing
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_arready_cause: assert property (
    $rose(s_axi_arready) |-> $past(s_axi_arvalid))
    else $error("arready without request");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bvalid_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without request");
endmodule
bind sao_core sao_props chk_i (.mclk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frame_sync_required,
  .hold_behaviour_select);

// file: tb/testbench.sv
module testbench
  import sao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic frame_sync_required, hold_behaviour_select;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count, total_checks;
  localparam logic [31:0] PV = 32'h8000_0F01;
  // Rows: status, product, acc, op, acc after, status after
  logic [31:0] tbl [9][6] = '{
    '{32'h06, PV, 32'h0, 32'h1, PV, 32'h06},
    '{32'h0E, PV, 32'h0, 32'h1, 32'h0000_1E02, 32'h0E},
    '{32'h16, PV, 32'h0, 32'h1, 32'h0000_F010, 32'h16},
    '{32'h1E, PV, 32'h0, 32'h1, 32'hFE00_003C, 32'h1E},
    '{32'h07, PV, 32'h8000_0001, 32'hA, 32'h0000_0003, 32'h07},
    '{32'h06, PV, 32'h4000_0000, 32'hA, 32'h8000_0000, 32'h06},
    '{32'h07, PV, 32'h0000_0002, 32'hB, 32'h8000_0001, 32'h06},
    '{32'h06, PV, 32'h0000_0001, 32'hB, 32'h0000_0000, 32'h07},
    '{32'h1F, PV, 32'h1234_5678, 32'h7, 32'h1234_5678, 32'h1E}};
  sao_core dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_sync_required,
    .hold_behaviour_select);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task results;
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // Each handshake is judged at the rising edge that moves it
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic dn;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    dn = 1'b0;
    r = 2'h0;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      dn = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
    end while (!dn && n < 40);
    s_axi_bready <= 1'b0;
    if (!dn) begin
      bad_count++;
      results;
    end else begin
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic dn;
    logic [31:0] v;
    logic [1:0] r;
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    dn = 1'b0;
    v = 32'h0;
    r = 2'h0;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      dn = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      n++;
    end while (!dn && n < 40);
    s_axi_rready <= 1'b0;
    if (!dn) begin
      bad_count++;
      results;
    end else begin
      chk(v, e);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk({31'h0, frame_sync_required & hold_behaviour_select}, 32'h1);
    rd(ADDR_STATUS, STATUS_RESET, RESP_OKAY);
    foreach (tbl[i]) begin
      for (int k = 0; k < 4; k++) wr(8'(4 * (3 - k)), tbl[i][k], RESP_OKAY);
      rd(ADDR_ACC, tbl[i][4], RESP_OKAY);
      rd(ADDR_STATUS, tbl[i][5], RESP_OKAY);
    end
    wr(ADDR_STATUS, 32'h06, RESP_OKAY);
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    rd(ADDR_STATUS, 32'h04, RESP_OKAY);
    wr(ADDR_CTRL, 32'h9, RESP_OKAY);
    rd(ADDR_STATUS, 32'h00, RESP_OKAY);
    chk({31'h0, frame_sync_required | hold_behaviour_select}, 32'h0);
    // Nine pushes: the first value must fall off the bottom
    for (int i = 1; i < 10; i++) begin
      wr(ADDR_MEM, 32'h1000 + i, RESP_OKAY);
      wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    end
    rd(ADDR_STACK_HEAD, 32'h1009, RESP_OKAY);
    wr(ADDR_STACK_HEAD, 32'h0, RESP_SLVERR);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    // Pops past the bottom keep returning the replicated value
    for (int j = 0; j < 10; j++) begin
      if (j % 3 == 0) wr(ADDR_ACC, 32'hFFFF_FFFF, RESP_OKAY);
      wr(ADDR_CTRL, (j % 3 == 0) ? 32'h2 : (j % 3 == 1) ? 32'h3 : 32'h6,
        RESP_OKAY);
      rd((j % 3 == 0) ? ADDR_ACC : (j % 3 == 1) ? ADDR_MEM : ADDR_PC,
        32'h1000 + ((j < 8) ? 9 - j : 2), RESP_OKAY);
    end
    wr(ADDR_ACC, 32'hABCD_1234, RESP_OKAY);
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    rd(ADDR_STACK_HEAD, 32'h1234, RESP_OKAY);
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_ACC, 32'h1234, RESP_OKAY);
    rd(ADDR_STACK_HEAD, 32'h1002, RESP_OKAY);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS, STATUS_RESET, RESP_OKAY);
    chk({31'h0, frame_sync_required & hold_behaviour_select}, 32'h1);
    results;
  end
endmodule
